//--- pkg/nefa_pkg.sv
// constants shared by the extended-resolution accumulator and its controller
`default_nettype none
package nefa_pkg;
  // ==========================================================
  // widths
  localparam int PHASE_W = 32;           // phase and timer accumulator width
  localparam int EXT_W   = 64;           // combined tuning resolution
  localparam int CBUS_AW = 2;            // control bus register select width
  localparam int AV_AW   = 5;            // avalon byte address width
  localparam int AV_DW   = 32;           // avalon data width
  // ==========================================================
  // device control bus register selects
  localparam logic [1:0] SEL_CENTER = 2'h0;
  localparam logic [1:0] SEL_TIMER  = 2'h1;
  localparam logic [1:0] SEL_PHASE  = 2'h2;
  // ==========================================================
  // controller register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_CENTER = 5'h08;
  localparam logic [4:0] OFS_TIMER  = 5'h0c;
  localparam logic [4:0] OFS_PHASE  = 5'h10;
  // ==========================================================
  // controller field positions
  localparam int CTRL_ROUTE_BIT = 0;     // board carry route enable
  localparam int CTRL_FREQ_BIT  = 1;     // start frequency update
  localparam int CTRL_PHASE_BIT = 2;     // start phase update
  localparam int STAT_BUSY_BIT  = 0;     // sequence in progress
  localparam int STAT_ROUTE_BIT = 1;     // route enable readback
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic        RST_ROUTE = 1'h1;
  // ==========================================================
  // timing: cycles between timer strobe and center strobe
  localparam int          STROBE_LEAD   = 2;
  localparam logic [1:0]  LEAD_CNT_INIT = 2'(STROBE_LEAD - 1);
  // ==========================================================
  // controller sequencer states
  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_WR_CF  = 8'h02,
    S_WR_TM  = 8'h04,
    S_STB_TM = 8'h08,
    S_GAP    = 8'h10,
    S_STB_CF = 8'h20,
    S_WR_PH  = 8'h40,
    S_STB_PH = 8'h80
  } nefa_state_type;
endpackage : nefa_pkg
`default_nettype wire

//--- pkg/nefa_link_if.sv
// board-level link between the accumulator device and its controller
`timescale 1ns/1ps
`default_nettype none
interface nefa_link_if;
  // control bus into the input holding registers
  logic [1:0]  cbus_sel;
  logic [31:0] cbus_data;
  logic        cbus_wr_n;
  // transfer strobes, active low
  logic        timer_load_strobe_n;
  logic        center_freq_load_strobe_n;
  logic        phase_load_strobe_n;
  // carry loop, carry pins active low, route enable active high
  logic        timer_carry_out_n;
  logic        phase_carry_in_n;
  logic        carry_route_en;

  // ==========================================================
  // board wiring: timer carry loops back to the phase carry input
  assign phase_carry_in_n = carry_route_en ? timer_carry_out_n : 1'b1;

  modport dev (
    input  cbus_sel,
    input  cbus_data,
    input  cbus_wr_n,
    input  timer_load_strobe_n,
    input  center_freq_load_strobe_n,
    input  phase_load_strobe_n,
    output timer_carry_out_n,
    input  phase_carry_in_n
  );

  modport ctl (
    output cbus_sel,
    output cbus_data,
    output cbus_wr_n,
    output timer_load_strobe_n,
    output center_freq_load_strobe_n,
    output phase_load_strobe_n,
    output carry_route_en
  );
endinterface : nefa_link_if
`default_nettype wire

//--- core/nefa_device.sv
// phase accumulator with timer accumulator extension to 64-bit resolution
//
// Function
// [RQ1] phase accumulator is 32 bits wide
// [RQ2] timer chained below phase gives 64-bit resolution
// [RQ3] controller writes timer register over control bus
// [RQ4] board routes timer carry to phase carry
// [RQ5] output frequency sums center and timer terms
// [RQ6] center frequency value is two's complement
// [RQ7] timer value unsigned, carry into phase lsb
// [RQ8] one flop each side, two-cycle carry latency
// [RQ9] timer strobe two cycles before center strobe
// [RQ10] timer loads on its own strobe pin
// [RQ11] holding registers move only on own strobe
// [RQ12] phase adjustable between frequency transfers
// [RQ13] extension leaves output quality unchanged
// [RQ14] phase adds frequency plus registered carry, wraps
`timescale 1ns/1ps
`default_nettype none
module nefa_device (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // link to the controller
  nefa_link_if.dev                         link,
  // user-side outputs
  output logic [nefa_pkg::PHASE_W-1:0]     phase_word,
  output logic [nefa_pkg::PHASE_W-1:0]     timer_word,
  output logic [nefa_pkg::PHASE_W-1:0]     center_word,
  output logic                             output_valid
);

  // ==========================================================
  // helpers

  // true when a control bus write targets the given holding register
  function automatic logic hold_write(input logic       wr_n,
                                      input logic [1:0] sel,
                                      input logic [1:0] code);
    hold_write = !wr_n && (sel == code);
  endfunction : hold_write

  // ==========================================================
  // declarations
  logic [nefa_pkg::PHASE_W-1:0] center_hold;
  logic [nefa_pkg::PHASE_W-1:0] timer_hold;
  logic [nefa_pkg::PHASE_W-1:0] phase_hold;
  logic [nefa_pkg::PHASE_W-1:0] center_op;
  logic [nefa_pkg::PHASE_W-1:0] timer_op;
  logic [nefa_pkg::PHASE_W-1:0] phase_op;
  logic [nefa_pkg::PHASE_W-1:0] timer_acc;
  logic [nefa_pkg::PHASE_W-1:0] phase_acc;
  logic                         carry_in_reg;
  logic                         wr_center;
  logic                         wr_timer;
  logic                         wr_phase;
  logic                         ld_center;
  logic                         ld_timer;
  logic                         ld_phase;
  logic [nefa_pkg::PHASE_W:0]   timer_sum;
  logic                         timer_carry;
  logic [nefa_pkg::PHASE_W-1:0] carry_word;
  logic [nefa_pkg::PHASE_W-1:0] next_phase_acc;
  logic [nefa_pkg::PHASE_W-1:0] next_timer_acc;
  logic [nefa_pkg::PHASE_W-1:0] next_phase_word;

  // ==========================================================
  // write and transfer decode

  // control bus selects one holding register per write
  assign wr_center = hold_write(link.cbus_wr_n, link.cbus_sel, nefa_pkg::SEL_CENTER);
  // [RQ3] timer written over bus
  assign wr_timer  = hold_write(link.cbus_wr_n, link.cbus_sel, nefa_pkg::SEL_TIMER);
  assign wr_phase  = hold_write(link.cbus_wr_n, link.cbus_sel, nefa_pkg::SEL_PHASE);

  // each operating register has a strobe of its own
  assign ld_center = !link.center_freq_load_strobe_n;
  // [RQ10] dedicated timer strobe
  assign ld_timer  = !link.timer_load_strobe_n;
  assign ld_phase  = !link.phase_load_strobe_n;

  // ==========================================================
  // input holding registers

  // [RQ11] separate holding registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      center_hold <= nefa_pkg::RST_WORD;
      timer_hold  <= nefa_pkg::RST_WORD;
      phase_hold  <= nefa_pkg::RST_WORD;
    end
    else
    begin
      if (wr_center)
        center_hold <= link.cbus_data;
      if (wr_timer)
        timer_hold <= link.cbus_data;
      if (wr_phase)
        phase_hold <= link.cbus_data;
    end
  end

  // ==========================================================
  // operating registers

  // [RQ11] transfer only on strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      center_op <= nefa_pkg::RST_WORD;
      timer_op  <= nefa_pkg::RST_WORD;
      phase_op  <= nefa_pkg::RST_WORD;
    end
    else
    begin
      if (ld_center)
        center_op <= center_hold;
      // [RQ10] timer transfer independent
      if (ld_timer)
        timer_op <= timer_hold;
      // [RQ12] phase loads between transfers
      if (ld_phase)
        phase_op <= phase_hold;
    end
  end

  // ==========================================================
  // timer accumulator arithmetic

  // [RQ7] unsigned timer sum, carry out
  assign timer_sum      = {1'b0, timer_acc} + {1'b0, timer_op};
  assign timer_carry    = timer_sum[nefa_pkg::PHASE_W];
  assign next_timer_acc = timer_sum[nefa_pkg::PHASE_W-1:0];

  // ==========================================================
  // phase accumulator arithmetic

  // carry widened so it lands on the phase lsb
  assign carry_word = {{(nefa_pkg::PHASE_W-1){1'b0}}, carry_in_reg};

  // [RQ14] frequency plus carry, wraps
  // [RQ6] two's complement adds as unsigned mod 2^32
  assign next_phase_acc = phase_acc + center_op + carry_word;

  // offset phase added after the accumulator, outside the frequency path
  assign next_phase_word = phase_acc + phase_op;

  // ==========================================================
  // timer accumulator and carry out flop

  // [RQ8] flop before carry pin
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      timer_acc              <= nefa_pkg::RST_WORD;
      link.timer_carry_out_n <= 1'b1;
    end
    else
    begin
      timer_acc              <= next_timer_acc;
      link.timer_carry_out_n <= !timer_carry;
    end
  end

  // ==========================================================
  // carry input flop

  // [RQ8] flop after carry pin
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      carry_in_reg <= 1'b0;
    else
      carry_in_reg <= !link.phase_carry_in_n;
  end

  // ==========================================================
  // phase accumulator

  // [RQ1] 32-bit phase accumulator
  // [RQ2] timer carry extends resolution
  // [RQ5] center/2^32 plus timer/2^64 per clock
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      phase_acc <= nefa_pkg::RST_WORD;
    else
      phase_acc <= next_phase_acc;
  end

  // ==========================================================
  // user-side outputs

  // [RQ13] output path same as normal mode
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      phase_word   <= nefa_pkg::RST_WORD;
      timer_word   <= nefa_pkg::RST_WORD;
      center_word  <= nefa_pkg::RST_WORD;
      output_valid <= 1'b0;
    end
    else
    begin
      phase_word   <= next_phase_word;
      timer_word   <= timer_op;
      center_word  <= center_op;
      // [RQ10] output never blanked by timer loads
      output_valid <= 1'b1;
    end
  end

endmodule : nefa_device
`default_nettype wire

//--- core/nefa_ctrl.sv
// controller: avalon-mm registers driving the accumulator load sequence
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nefa_ctrl (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  // avalon-mm slave
  input  wire logic [nefa_pkg::AV_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [nefa_pkg::AV_DW-1:0] avs_writedata,
  output logic      [nefa_pkg::AV_DW-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  // link to the device
  nefa_link_if.ctl                        link
);

  // ==========================================================
  // declarations
  nefa_pkg::nefa_state_type     state;
  nefa_pkg::nefa_state_type     next_state;
  logic [31:0]                  center_val;
  logic [31:0]                  timer_val;
  logic [31:0]                  phase_val;
  logic                         route_en;
  logic [1:0]                   lead_cnt;
  logic                         take_wr;
  logic                         take_rd;
  logic                         busy;
  logic                         wr_ctrl;
  logic                         go_freq;
  logic                         go_phase;
  logic [31:0]                  read_mux;

  // ==========================================================
  // bus decode: a request is taken in the cycle waitrequest is low
  assign take_wr  = avs_write && !avs_waitrequest;
  assign take_rd  = avs_read && !avs_waitrequest;
  assign busy     = (state != nefa_pkg::S_IDLE);
  assign wr_ctrl  = take_wr && (avs_address == nefa_pkg::OFS_CTRL);
  assign go_freq  = wr_ctrl && !busy && avs_writedata[nefa_pkg::CTRL_FREQ_BIT];
  assign go_phase = wr_ctrl && !busy && avs_writedata[nefa_pkg::CTRL_PHASE_BIT]
                    && !avs_writedata[nefa_pkg::CTRL_FREQ_BIT];
  assign read_mux =
    (avs_address == nefa_pkg::OFS_CTRL)   ? {31'h0, route_en} :
    (avs_address == nefa_pkg::OFS_STATUS) ? {30'h0, route_en, busy} :
    (avs_address == nefa_pkg::OFS_CENTER) ? center_val :
    (avs_address == nefa_pkg::OFS_TIMER)  ? timer_val :
    (avs_address == nefa_pkg::OFS_PHASE)  ? phase_val : 32'h0;

  // ==========================================================
  // waitrequest drops for one cycle after each request, read data with it
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= read_mux;
    end
  end

  // ==========================================================
  // software registers; values are locked while a sequence runs
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      center_val <= nefa_pkg::RST_WORD;
      timer_val  <= nefa_pkg::RST_WORD;
      phase_val  <= nefa_pkg::RST_WORD;
      route_en   <= nefa_pkg::RST_ROUTE;
    end
    else if (take_wr && !busy)
    begin
      if (avs_address == nefa_pkg::OFS_CENTER)
        center_val <= avs_writedata;
      if (avs_address == nefa_pkg::OFS_TIMER)
        timer_val <= avs_writedata;
      if (avs_address == nefa_pkg::OFS_PHASE)
        phase_val <= avs_writedata;
      if (avs_address == nefa_pkg::OFS_CTRL)
        route_en <= avs_writedata[nefa_pkg::CTRL_ROUTE_BIT];
    end
  end

  // ==========================================================
  // sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      nefa_pkg::S_IDLE:
        if (go_freq)
          next_state = nefa_pkg::S_WR_CF;
        else if (go_phase)
          next_state = nefa_pkg::S_WR_PH;
      nefa_pkg::S_WR_CF:  next_state = nefa_pkg::S_WR_TM;
      nefa_pkg::S_WR_TM:  next_state = nefa_pkg::S_STB_TM;
      nefa_pkg::S_STB_TM: next_state = nefa_pkg::S_GAP;
      nefa_pkg::S_GAP:
        if (lead_cnt == 2'h0)
          next_state = nefa_pkg::S_STB_CF;
      nefa_pkg::S_STB_CF: next_state = nefa_pkg::S_IDLE;
      nefa_pkg::S_WR_PH:  next_state = nefa_pkg::S_STB_PH;
      nefa_pkg::S_STB_PH: next_state = nefa_pkg::S_IDLE;
      default:            next_state = nefa_pkg::S_IDLE;
    endcase
  end

  // ==========================================================
  // state and lead counter
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state    <= nefa_pkg::S_IDLE;
      lead_cnt <= 2'h0;
    end
    else
    begin
      state    <= next_state;
      lead_cnt <= (next_state == nefa_pkg::S_STB_TM) ? nefa_pkg::LEAD_CNT_INIT
                : (lead_cnt != 2'h0) ? lead_cnt - 2'h1 : lead_cnt;
    end
  end

  // ==========================================================
  // link outputs registered from the next state, carry_route_en from route_en
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      link.cbus_sel                  <= nefa_pkg::SEL_CENTER;
      link.cbus_data                 <= nefa_pkg::RST_WORD;
      link.cbus_wr_n                 <= 1'b1;
      link.timer_load_strobe_n       <= 1'b1;
      link.center_freq_load_strobe_n <= 1'b1;
      link.phase_load_strobe_n       <= 1'b1;
      link.carry_route_en            <= nefa_pkg::RST_ROUTE;
    end
    else
    begin
      // [RQ3] timer value over the bus
      link.cbus_wr_n <= !(next_state == nefa_pkg::S_WR_CF ||
                          next_state == nefa_pkg::S_WR_TM ||
                          next_state == nefa_pkg::S_WR_PH);
      link.cbus_sel  <= (next_state == nefa_pkg::S_WR_TM) ? nefa_pkg::SEL_TIMER
                      : (next_state == nefa_pkg::S_WR_PH) ? nefa_pkg::SEL_PHASE
                      : nefa_pkg::SEL_CENTER;
      link.cbus_data <= (next_state == nefa_pkg::S_WR_TM) ? timer_val
                      : (next_state == nefa_pkg::S_WR_PH) ? phase_val
                      : center_val;
      // [RQ9] timer strobe leads by two
      link.timer_load_strobe_n       <= (next_state != nefa_pkg::S_STB_TM);
      link.center_freq_load_strobe_n <= (next_state != nefa_pkg::S_STB_CF);
      // [RQ12] phase between frequency loads
      link.phase_load_strobe_n       <= (next_state != nefa_pkg::S_STB_PH);
      // [RQ4] carry loop routed on board
      link.carry_route_en            <= route_en;
    end
  end

endmodule : nefa_ctrl
`default_nettype wire

//--- tb/nefa_properties.sv
// concurrent checks on the carry loop, strobes and device outputs
`timescale 1ns/1ps
`default_nettype none
module nefa_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // control bus and strobes
  input wire logic [1:0]  cbus_sel,
  input wire logic        cbus_wr_n,
  input wire logic        timer_load_strobe_n,
  input wire logic        center_freq_load_strobe_n,
  input wire logic        phase_load_strobe_n,
  // carry loop
  input wire logic        phase_carry_in_n,
  // device outputs
  input wire logic [31:0] phase_word,
  input wire logic [31:0] timer_word,
  input wire logic [31:0] center_word
);
  logic [2:0] up_cnt;

  // ==========================================================
  // cycles since reset release, so $past never reaches into reset
  always_ff @(posedge mclk)
    if (!rst_b)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // strobe order and control bus writes
  // timer leads center
  chk_timer_lead: assert property (!timer_load_strobe_n |-> ##2 !center_freq_load_strobe_n)
    else $error("center strobe missing two cycles after timer strobe");
  chk_center_lag: assert property (!center_freq_load_strobe_n |-> $past(timer_load_strobe_n, 2) == 1'b0)
    else $error("center strobe without timer strobe two cycles earlier");
  chk_strobe_pulse: assert property (!timer_load_strobe_n |=> timer_load_strobe_n [*3])
    else $error("timer strobe longer than one cycle");
  chk_timer_wr: assert property (!timer_load_strobe_n |->
    $past(!cbus_wr_n && cbus_sel == nefa_pkg::SEL_TIMER))
    else $error("timer strobe not preceded by timer write");
  chk_center_wr: assert property (!center_freq_load_strobe_n |->
    $past(!cbus_wr_n && cbus_sel == nefa_pkg::SEL_CENTER, 4))
    else $error("center strobe not preceded by center write");
  chk_phase_wr: assert property (!phase_load_strobe_n |->
    $past(!cbus_wr_n && cbus_sel == nefa_pkg::SEL_PHASE))
    else $error("phase strobe not preceded by phase write");

  // ==========================================================
  // operating registers and accumulation
  // center moves on strobe
  chk_center_hold: assert property (up_cnt == 3'h7 && $changed(center_word) |->
    $past(center_freq_load_strobe_n, 2) == 1'b0)
    else $error("center value changed without its strobe");
  chk_timer_hold: assert property (up_cnt == 3'h7 && $changed(timer_word) |->
    $past(timer_load_strobe_n, 2) == 1'b0)
    else $error("timer value changed without its strobe");
  chk_phase_step: assert property (up_cnt == 3'h7 && phase_load_strobe_n
    && $past(phase_load_strobe_n) && $past(phase_load_strobe_n, 2) && $past(phase_load_strobe_n, 3)
    |-> phase_word - $past(phase_word) ==
        $past(center_word) + {31'h0, !$past(phase_carry_in_n, 3)})
    else $error("phase step differs from frequency plus delayed carry");
endmodule : nefa_properties
`default_nettype wire

//--- tb/nefa_tb_top.sv
// self-checking bench: controller and device joined through the link
`timescale 1ns/1ps
`default_nettype none
module nefa_tb_top;
  logic        mclk;
  logic        rst_b;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] phase_word;
  logic [31:0] timer_word;
  logic [31:0] center_word;
  logic        output_valid;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [31:0] last_rd;
  logic [31:0] cyc;
  int          n_fail;
  int          total_checks;

  // ==========================================================
  // both ends, the link and the checker
  nefa_link_if u_link ();
  nefa_ctrl u_nefa_ctrl (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(u_link));
  nefa_device u_nefa_device (.mclk(mclk), .rst_b(rst_b), .link(u_link),
    .phase_word(phase_word), .timer_word(timer_word), .center_word(center_word),
    .output_valid(output_valid));
  nefa_properties u_nefa_properties (.mclk(mclk), .rst_b(rst_b),
    .cbus_sel(u_link.cbus_sel), .cbus_wr_n(u_link.cbus_wr_n),
    .timer_load_strobe_n(u_link.timer_load_strobe_n),
    .center_freq_load_strobe_n(u_link.center_freq_load_strobe_n),
    .phase_load_strobe_n(u_link.phase_load_strobe_n),
    .phase_carry_in_n(u_link.phase_carry_in_n), .phase_word(phase_word),
    .timer_word(timer_word), .center_word(center_word));

  // ==========================================================
  // clock, cycle count and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
    cyc <= cyc + 32'h1;

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  // ==========================================================
  // compare, bus transfer and verdict tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    int n;
    @(posedge mclk);
    if (rd)
    begin
      exp_q.push_back(d);
      mask_q.push_back(m);
    end
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    last_rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      av(1'b1, nefa_pkg::OFS_STATUS, 32'h0, 32'h0);
      n++;
    end
    while (last_rd[nefa_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
    repeat (8) @(posedge mclk);
  endtask : wait_idle

  task automatic span(input int n, input logic [31:0] exp);
    logic [31:0] p0;
    @(negedge mclk);
    p0 = phase_word;
    repeat (n) @(negedge mclk);
    chk(phase_word - p0, exp, "phase advance");
  endtask : span

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // ==========================================================
  // read monitor: oldest note against each accepted read
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      if (mask_q[0] != 32'h0)
        chk(avs_readdata & mask_q[0], exp_q[0] & mask_q[0], "readdata");
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] v0;
    logic [31:0] v1;
    logic [31:0] p0;
    logic [31:0] t0;
    rst_b = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cyc = 32'h0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(32'h01b1));
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    av(1'b1, nefa_pkg::OFS_CTRL, 32'h1, 32'h7);
    av(1'b1, nefa_pkg::OFS_STATUS, 32'h2, 32'h3);
    av(1'b1, 5'h14, 32'h0, 32'hffff_ffff);
    repeat (3)
    begin
      v0 = $urandom();
      v1 = $urandom();
      av(1'b0, nefa_pkg::OFS_CENTER, v0, 32'h0);
      av(1'b0, nefa_pkg::OFS_TIMER, v1, 32'h0);
      av(1'b1, nefa_pkg::OFS_TIMER, v1, 32'hffff_ffff);
      av(1'b0, nefa_pkg::OFS_CTRL, 32'h3, 32'h0);
      av(1'b0, nefa_pkg::OFS_CENTER, ~v0, 32'h0);
      wait_idle();
      chk(center_word, v0, "center");
      chk(timer_word, v1, "timer");
      av(1'b1, nefa_pkg::OFS_CENTER, v0, 32'hffff_ffff);
    end
    av(1'b0, nefa_pkg::OFS_CENTER, 32'h3, 32'h0);
    av(1'b0, nefa_pkg::OFS_TIMER, 32'h4000_0000, 32'h0);
    av(1'b0, nefa_pkg::OFS_CTRL, 32'h3, 32'h0);
    wait_idle();
    span(400, 32'd1300);
    av(1'b0, nefa_pkg::OFS_CTRL, 32'h0, 32'h0);
    av(1'b1, nefa_pkg::OFS_STATUS, 32'h0, 32'h2);
    repeat (4) @(posedge mclk);
    span(400, 32'd1200);
    av(1'b0, nefa_pkg::OFS_CTRL, 32'h1, 32'h0);
    av(1'b0, nefa_pkg::OFS_CENTER, 32'hffff_fffb, 32'h0);
    av(1'b0, nefa_pkg::OFS_TIMER, 32'h0, 32'h0);
    av(1'b0, nefa_pkg::OFS_CTRL, 32'h3, 32'h0);
    wait_idle();
    span(100, 32'hffff_fe0c);
    v0 = $urandom();
    @(negedge mclk);
    p0 = phase_word;
    t0 = cyc;
    av(1'b0, nefa_pkg::OFS_PHASE, v0, 32'h0);
    av(1'b0, nefa_pkg::OFS_CTRL, 32'h5, 32'h0);
    wait_idle();
    @(negedge mclk);
    chk(phase_word - p0, (cyc - t0) * 32'hffff_fffb + v0, "phase jump");
    chk(center_word, 32'hffff_fffb, "center kept");
    test_done();
  end
endmodule : nefa_tb_top
`default_nettype wire
